//--- rtl/fifo_expansion_chain_pkg.sv
// constants shared by the fifo expansion stage
package fifo_expansion_chain_pkg;

    // ------------------------------------------------------------
    // storage geometry
    // ------------------------------------------------------------
    localparam int DATA_W = 40;
    localparam int PTR_W = 14;
    localparam int CNT_W = 15;
    localparam int LVL_W = 16;
    localparam logic [CNT_W-1:0] DEPTH = 15'h4000;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] AE_OFFSET_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] LEVEL_OFS = 8'h0c;

    // ctrl fields
    localparam int CTRL_FIRST_WORD_FALL_THROUGH_MODE_BIT = 0;
    localparam int CTRL_MRST_BIT = 1;
    localparam logic CTRL_FIRST_WORD_FALL_THROUGH_MODE_RST = 1'h1;

    // status fields
    localparam int ST_EMPTY_BIT = 0;
    localparam int ST_FULL_BIT = 1;
    localparam int ST_AE_BIT = 2;
    localparam int ST_FIRST_WORD_FALL_THROUGH_MODE_BIT = 3;
    localparam int ST_OVALID_BIT = 4;

    // almost-empty offset after reset
    localparam logic [LVL_W-1:0] AE_OFFSET_RST = 16'h0007;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : fifo_expansion_chain_pkg

//--- rtl/fifo_expansion_chain.sv
// one fifo stage for width or depth expansion, with axi4-lite control
//
// Contract
// RL1 - almost-empty flag changes only on the read-side clock edge.
// RL2 - close write/read edges may delay almost-empty release one cycle.
// RL3 - width expansion: controls tied together; composite flags taken outside.
// RL4 - grouped stages may release flags one cycle apart from each other.
// RL5 - standard mode: outside logic ANDs empty flags, and full flags.
// RL6 - fall-through mode: outside logic ORs ready flags of all stages.
// RL7 - width-grouped stages have equal depth; outputs never wired together.
// RL8 - depth chain: data out feeds next data in, no added logic.
// RL9 - every stage of a depth chain starts in fall-through mode.
// RL10 - every chained stage runs single data rate.
// RL11 - first word ripples down alone; read clock keeps running.
// RL12 - word at outputs drives output-ready low, enabling next write.
// RL13 - empty chain: last output-ready low within stated latency bound.
// RL14 - only first word into empty chain shows ripple latency.
// RL15 - free location from full chain moves back stage by stage.
// RL16 - stage gaining free space drives input-ready low.
// RL17 - full chain: first input-ready low within stated latency bound.
// RL18 - latency budgets allow extra cycles for unmet clock skew.
// RL19 - transfer clock ties to the faster of write and read clocks.
// RL20 - first word falls through regardless; later reads need both enables.
// RL21 - neighbours: output-ready drives write enable, input-ready read enable.
`timescale 1ns/1ps
`default_nettype none

module fifo_expansion_chain
    import fifo_expansion_chain_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // write side
    input wire logic write_enable_n,
    input wire logic [DATA_W-1:0] data_in,
    // read side
    input wire logic read_enable_n,
    input wire logic read_chip_select_n,
    output logic [DATA_W-1:0] data_out,
    // flags
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic output_ready_n,
    output logic input_ready_n,
    output logic almost_empty_flag_n,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PTR_W-1:0] wptr;
        logic [PTR_W-1:0] rptr;
        logic [CNT_W-1:0] mem_cnt;
        logic out_valid;
        logic [DATA_W-1:0] dout;
        logic first_word_fall_through_mode;
        logic empty_n;
        logic full_n;
        logic oready_n;
        logic iready_n;
        logic ae_n;
        logic first_word_fall_through_mode_sel;
        logic [LVL_W-1:0] ae_offset;
        logic aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // storage kept apart from the struct so it maps to ram
    logic [DATA_W-1:0] mem [0:(1<<PTR_W)-1];

    logic do_write;
    logic do_read_std;
    logic pop_out;
    logic load_out;
    logic mem_pop;
    logic mrst;
    logic [LVL_W-1:0] level_nxt;
    logic [31:0] status_word;

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        mrst = 1'b0;
        do_write = 1'b0;
        do_read_std = 1'b0;
        pop_out = 1'b0;
        load_out = 1'b0;
        mem_pop = 1'b0;
        level_nxt = '0;
        status_word = '0;

        // data path; a write into a full stage is dropped
        do_write = !write_enable_n && (st_r.mem_cnt != DEPTH);
        if (st_r.first_word_fall_through_mode)
        begin
            // RL20 later reads need enables
            pop_out = !read_enable_n && !read_chip_select_n
                && st_r.out_valid;
            // RL13 one-edge load per stage
            // RL11 first word falls through
            load_out = (st_r.mem_cnt != '0)
                && (!st_r.out_valid || pop_out);
            mem_pop = load_out;
            if (load_out)
            begin
                st_nxt.dout = mem[st_r.rptr];
                st_nxt.out_valid = 1'b1;
            end
            else if (pop_out)
            begin
                st_nxt.out_valid = 1'b0;
            end
        end
        else
        begin
            do_read_std = !read_enable_n && !read_chip_select_n
                && (st_r.mem_cnt != '0);
            mem_pop = do_read_std;
            if (do_read_std)
            begin
                st_nxt.dout = mem[st_r.rptr];
            end
        end

        if (do_write)
        begin
            st_nxt.wptr = st_r.wptr + 14'h1;
        end
        if (mem_pop)
        begin
            st_nxt.rptr = st_r.rptr + 14'h1;
        end
        // RL14 later words skip ripple delay
        st_nxt.mem_cnt = st_r.mem_cnt + {14'h0, do_write}
            - {14'h0, mem_pop};
        level_nxt = {1'b0, st_nxt.mem_cnt} + {15'h0, st_nxt.out_valid};

        // flags, all registered on the single clock
        if (st_r.first_word_fall_through_mode)
        begin
            st_nxt.empty_n = 1'b1;
            st_nxt.full_n = 1'b1;
            // RL12 word shown, ready low
            st_nxt.oready_n = !st_nxt.out_valid;
            // RL15 RL17 freed slot shown next edge
            // RL16 free space, ready low
            st_nxt.iready_n = (st_nxt.mem_cnt == DEPTH);
        end
        else
        begin
            st_nxt.empty_n = (st_nxt.mem_cnt != '0);
            st_nxt.full_n = (st_nxt.mem_cnt != DEPTH);
            st_nxt.oready_n = 1'b1;
            st_nxt.iready_n = 1'b1;
        end
        // RL2 RL4 one clock, so no skew delay
        // RL1 almost-empty on clock edge
        st_nxt.ae_n = (level_nxt > st_r.ae_offset);

        // status view of own state
        status_word[ST_EMPTY_BIT] = (level_nxt == '0);
        status_word[ST_FULL_BIT] = (st_r.mem_cnt == DEPTH);
        status_word[ST_AE_BIT] = !st_r.ae_n;
        status_word[ST_FIRST_WORD_FALL_THROUGH_MODE_BIT] = st_r.first_word_fall_through_mode;
        status_word[ST_OVALID_BIT] = st_r.out_valid;

        // ------------------------------------------------------------
        // axi4-lite write
        // ------------------------------------------------------------
        if (s_axi_awvalid && !st_r.aw_held && !st_r.bvalid)
        begin
            st_nxt.aw_held = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.w_held && !st_r.bvalid)
        begin
            st_nxt.w_held = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.aw_held && st_r.w_held)
        begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = RESP_OKAY;
            unique case (st_r.awaddr[ADDR_W-1:2])
                CTRL_OFS[ADDR_W-1:2]:
                begin
                    if (st_r.wstrb[0])
                    begin
                        st_nxt.first_word_fall_through_mode_sel = st_r.wdata[CTRL_FIRST_WORD_FALL_THROUGH_MODE_BIT];
                        mrst = st_r.wdata[CTRL_MRST_BIT];
                    end
                end
                AE_OFFSET_OFS[ADDR_W-1:2]:
                begin
                    st_nxt.ae_offset = LVL_W'(merge_bytes(
                        {16'h0, st_r.ae_offset}, st_r.wdata,
                        st_r.wstrb));
                end
                STATUS_OFS[ADDR_W-1:2], LEVEL_OFS[ADDR_W-1:2]:
                begin
                    // read-only, write ignored
                end
                default:
                begin
                    st_nxt.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (st_r.bvalid && s_axi_bready)
        begin
            st_nxt.bvalid = 1'b0;
        end

        // ------------------------------------------------------------
        // axi4-lite read
        // ------------------------------------------------------------
        if (st_r.rvalid && s_axi_rready)
        begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st_r.rvalid)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OKAY;
            unique case (s_axi_araddr[ADDR_W-1:2])
                CTRL_OFS[ADDR_W-1:2]:
                    st_nxt.rdata = {31'h0, st_r.first_word_fall_through_mode_sel};
                AE_OFFSET_OFS[ADDR_W-1:2]:
                    st_nxt.rdata = {16'h0, st_r.ae_offset};
                STATUS_OFS[ADDR_W-1:2]:
                    st_nxt.rdata = status_word;
                LEVEL_OFS[ADDR_W-1:2]:
                    st_nxt.rdata = {16'h0, {1'b0, st_r.mem_cnt}
                        + {15'h0, st_r.out_valid}};
                default:
                begin
                    st_nxt.rdata = 32'h0;
                    st_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end

        // ------------------------------------------------------------
        // master reset from software
        // ------------------------------------------------------------
        // mode only changes here, so a live stage never switches timing
        if (mrst)
        begin
            st_nxt.wptr = '0;
            st_nxt.rptr = '0;
            st_nxt.mem_cnt = '0;
            st_nxt.out_valid = 1'b0;
            st_nxt.dout = '0;
            // RL9 mode taken at master reset
            st_nxt.first_word_fall_through_mode = st_nxt.first_word_fall_through_mode_sel;
            st_nxt.empty_n = st_nxt.first_word_fall_through_mode_sel;
            st_nxt.full_n = 1'b1;
            st_nxt.oready_n = 1'b1;
            st_nxt.iready_n = !st_nxt.first_word_fall_through_mode_sel;
            st_nxt.ae_n = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.first_word_fall_through_mode <= CTRL_FIRST_WORD_FALL_THROUGH_MODE_RST;
            st_r.first_word_fall_through_mode_sel <= CTRL_FIRST_WORD_FALL_THROUGH_MODE_RST;
            st_r.empty_n <= CTRL_FIRST_WORD_FALL_THROUGH_MODE_RST;
            st_r.full_n <= 1'b1;
            st_r.oready_n <= 1'b1;
            st_r.iready_n <= !CTRL_FIRST_WORD_FALL_THROUGH_MODE_RST;
            st_r.ae_offset <= AE_OFFSET_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // RL8 stored word order kept
    always_ff @(posedge core_clk)
    begin
        if (do_write && !mrst)
        begin
            mem[st_r.wptr] <= data_in;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign data_out = st_r.dout;
    assign empty_flag_n = st_r.empty_n;
    assign full_flag_n = st_r.full_n;
    assign output_ready_n = st_r.oready_n;
    assign input_ready_n = st_r.iready_n;
    assign almost_empty_flag_n = st_r.ae_n;
    assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;

endmodule : fifo_expansion_chain

`default_nettype wire

//--- verification/fifo_expansion_chain_props.sv
// concurrent checks on the fifo stage ports
`timescale 1ns/1ps
`default_nettype none
module fifo_expansion_chain_props
    import fifo_expansion_chain_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // data side
    input wire logic write_enable_n,
    input wire logic read_enable_n,
    input wire logic read_chip_select_n,
    input wire logic [DATA_W-1:0] data_out,
    // flags
    input wire logic empty_flag_n,
    input wire logic full_flag_n,
    input wire logic output_ready_n,
    input wire logic input_ready_n,
    input wire logic almost_empty_flag_n,
    // register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_first_word: assert property (
        output_ready_n && !input_ready_n && !write_enable_n
        |-> ##2 !output_ready_n) else $error("first word late");
    // bus write in flight may master-reset the stage
    a_word_holds: assert property (
        !output_ready_n && (read_enable_n || read_chip_select_n)
        && s_axi_awready && !s_axi_awvalid
        |=> !output_ready_n && $stable(data_out))
        else $error("word left without read");
    a_space_back: assert property (
        input_ready_n && !output_ready_n && !read_enable_n
        && !read_chip_select_n |-> ##[1:2] !input_ready_n)
        else $error("free space late");
    a_ready_mode: assert property (
        !output_ready_n |-> empty_flag_n && full_flag_n)
        else $error("standard flags in fall-through");
    a_empty_std: assert property (
        !empty_flag_n |-> output_ready_n && input_ready_n
        && !almost_empty_flag_n) else $error("empty flag mix");
    a_ae_cause: assert property (
        $changed(almost_empty_flag_n) |-> $past(!write_enable_n)
        || $past(!write_enable_n, 2) || $past(!read_enable_n)
        || $past(!read_enable_n, 2) || $past(s_axi_wvalid)
        || $past(s_axi_wvalid, 2)) else $error("almost-empty moved");
    a_write_resp: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("bvalid late");
    a_read_resp: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("rvalid late");
    a_write_block: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
endmodule : fifo_expansion_chain_props
bind fifo_expansion_chain fifo_expansion_chain_props props (.*);
`default_nettype wire

//--- verification/fifo_reader_model.sv
// downstream reader model facing the stage outputs
`timescale 1ns/1ps
`default_nettype none
module fifo_reader_model
    import fifo_expansion_chain_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // scenario control
    input wire logic en_off,
    input wire logic cs_off,
    // stage outputs
    input wire logic output_ready_n,
    input wire logic [DATA_W-1:0] data_out,
    // read controls and capture
    output logic read_enable_n,
    output logic read_chip_select_n,
    output logic got,
    output logic [DATA_W-1:0] word
);
    // ------------------------------------------------------------
    // reader
    // ------------------------------------------------------------
    // one free-running clock
    always_ff @(posedge core_clk)
    begin
        word <= data_out;
        if (!rst_n)
        begin
            read_enable_n <= 1'b1;
            read_chip_select_n <= 1'b1;
            got <= 1'b0;
        end
        else
        begin
            read_enable_n <= en_off;
            read_chip_select_n <= cs_off;
            got <= !read_enable_n && !read_chip_select_n && !output_ready_n;
        end
    end
endmodule : fifo_reader_model
`default_nettype wire

//--- verification/fifo_expansion_chain_bench.sv
// self-checking bench for the fifo stage
`timescale 1ns/1ps
`default_nettype none
module fifo_expansion_chain_bench
    import fifo_expansion_chain_pkg::*;
;
    // ------------------------------------------------------------
    // signals, instances, helpers
    // ------------------------------------------------------------
    logic core_clk, rst_n, write_enable_n, read_enable_n;
    logic read_chip_select_n, en_off, cs_off, got;
    logic [DATA_W-1:0] data_in, data_out, word;
    logic empty_flag_n, full_flag_n, output_ready_n, input_ready_n;
    logic almost_empty_flag_n;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [DATA_W-1:0] exp_q[$];
    int bad_count, n_checks;
    // composite of one is own flag
    fifo_expansion_chain uut (.*);
    fifo_reader_model reader (.*);
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_bit
    task automatic chk_word(input string nm, input logic [DATA_W-1:0] e,
        input logic [DATA_W-1:0] g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word
    task automatic results();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic wr_n(input logic [DATA_W-1:0] b, input int n, input bit p);
        @(posedge core_clk);
        write_enable_n <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            data_in <= b + DATA_W'(i);
            if (p)
                exp_q.push_back(b + DATA_W'(i));
            @(posedge core_clk);
        end
        write_enable_n <= 1'b1;
    endtask : wr_n
    // one read pulse from the reader model
    task automatic pop1();
        @(posedge core_clk);
        en_off <= 1'b0;
        @(posedge core_clk);
        en_off <= 1'b1;
        tick(1);
    endtask : pop1
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        while (s_axi_bvalid !== 1'b1)
            @(posedge core_clk);
        s_axi_bready <= 1'b0;
        chk_word("bresp", {38'h0, er}, {38'h0, s_axi_bresp});
    endtask : wr_chk
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk_word("rdata", {8'h0, e}, {8'h0, s_axi_rdata});
        chk_word("rresp", {38'h0, er}, {38'h0, s_axi_rresp});
    endtask : rd_chk
    // passed words come out in write order
    always @(posedge core_clk)
        if (got === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk_bit("extra_word", 1'b0, 1'b1);
            else
                chk_word("rd_word", exp_q.pop_front(), word);
        end
    initial
    begin
        repeat (60000) @(posedge core_clk);
        bad_count++;
        results();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_fall();
        tick(1);
        chk_bit("ir_rst", 1'b0, input_ready_n);
        chk_bit("or_rst", 1'b1, output_ready_n);
        chk_bit("ae_rst", 1'b0, almost_empty_flag_n);
        wr_n(40'h0a, 1, 1'b1);
        tick(0);
        chk_bit("or_early", 1'b1, output_ready_n);
        tick(1);
        chk_bit("or_fall", 1'b0, output_ready_n);
        chk_word("q_fall", 40'h0a, data_out);
    endtask : t_fall
    task automatic t_cs();
        @(posedge core_clk);
        cs_off <= 1'b1;
        en_off <= 1'b0;
        tick(5);
        chk_bit("cs_hold", 1'b1, exp_q.size() == 1);
        @(posedge core_clk);
        cs_off <= 1'b0;
        tick(3);
        chk_bit("cs_read", 1'b1, exp_q.size() == 0);
        chk_bit("or_gone", 1'b1, output_ready_n);
    endtask : t_cs
    task automatic t_stream();
        wr_n(40'h100, 4, 1'b1);
        tick(4);
        chk_bit("stream", 1'b1, exp_q.size() == 0);
    endtask : t_stream
    task automatic t_full();
        @(posedge core_clk);
        en_off <= 1'b1;
        wr_n(40'h1000, 16385, 1'b1);
        wr_n(40'hff_ffff_ffff, 1, 1'b0);
        tick(2);
        chk_bit("ir_full", 1'b1, input_ready_n);
        chk_bit("ae_full", 1'b1, almost_empty_flag_n);
        pop1();
        tick(1);
        chk_bit("ir_back", 1'b0, input_ready_n);
        @(posedge core_clk);
        en_off <= 1'b0;
        while (exp_q.size() != 0)
            @(posedge core_clk);
        tick(3);
        chk_bit("or_drain", 1'b1, output_ready_n);
        chk_bit("ae_drain", 1'b0, almost_empty_flag_n);
    endtask : t_full
    task automatic t_std();
        rd_chk(CTRL_OFS, 32'h1, RESP_OKAY);
        rd_chk(AE_OFFSET_OFS, 32'h7, RESP_OKAY);
        rd_chk(8'h10, 32'h0, RESP_SLVERR);
        wr_chk(8'h10, 32'h1, RESP_SLVERR);
        wr_chk(AE_OFFSET_OFS, 32'h2, RESP_OKAY);
        rd_chk(AE_OFFSET_OFS, 32'h2, RESP_OKAY);
        @(posedge core_clk);
        en_off <= 1'b1;
        wr_chk(CTRL_OFS, 32'h2, RESP_OKAY);
        tick(1);
        chk_bit("ef_std", 1'b0, empty_flag_n);
        wr_n(40'h200, 3, 1'b0);
        tick(2);
        chk_bit("ef_fill", 1'b1, empty_flag_n);
        chk_bit("ff_fill", 1'b1, full_flag_n);
        chk_bit("ae_above", 1'b1, almost_empty_flag_n);
        pop1();
        chk_word("q_std", 40'h200, data_out);
        tick(1);
        chk_bit("ae_at", 1'b0, almost_empty_flag_n);
        rd_chk(LEVEL_OFS, 32'h2, RESP_OKAY);
        rd_chk(STATUS_OFS, 32'h4, RESP_OKAY);
        wr_chk(CTRL_OFS, 32'h3, RESP_OKAY);
        tick(1);
        chk_bit("ir_ft", 1'b0, input_ready_n);
    endtask : t_std
    initial
    begin
        rst_n = 1'b0;
        write_enable_n = 1'b1;
        data_in = '0;
        en_off = 1'b1;
        cs_off = 1'b0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        bad_count = 0;
        n_checks = 0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        t_fall();
        t_cs();
        t_stream();
        t_full();
        t_std();
        results();
    end
endmodule : fifo_expansion_chain_bench
`default_nettype wire
